// file: rtl/bdt_defines.svh
// Offsets, field positions, reset values and timing counts of the dim/off timer
`ifndef BDT_DEFINES_SVH
`define BDT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BDT_SINK_SELECT_ADDR   8'h05
`define BDT_OFF_DELAY_ADDR     8'h06
`define BDT_DIM_DELAY_ADDR     8'h07

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define BDT_FIELD_MSB          6
`define BDT_SINK_COUNT         7
`define BDT_SINK_SELECT_RESET  7'h00
`define BDT_OFF_DELAY_RESET    7'h00
`define BDT_DIM_DELAY_RESET    7'h00
`define BDT_FADE_DISABLED      4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BDT_CLK_PERIOD_NS      10
`define BDT_SECOND_NS          1000000000
`define BDT_SECOND_CYCLES      (`BDT_SECOND_NS / `BDT_CLK_PERIOD_NS)

`endif

// file: rtl/bdt_pkg.sv
// Types shared by the dim/off timer modules
package bdt_pkg;

  // Timeout sequencer states
  typedef enum logic [2:0] {
    BDT_IDLE,
    BDT_WAIT_MAX,
    BDT_DIM_RUN,
    BDT_OFF_RUN,
    BDT_HOLD
  } bdt_state_t;

  typedef logic [6:0] bdt_field_t;

endpackage : bdt_pkg

// file: rtl/bdt_tick_if.sv
// Carrier between the sequencer and its one-second tick source
`timescale 1ns/1ps
`default_nettype none

interface bdt_tick_if;
  logic clear;   // Restart the second
  logic tick;    // One-cycle pulse per second

  modport source (input clear, output tick);
  modport user   (output clear, input tick);
endinterface : bdt_tick_if

`default_nettype wire

// file: rtl/bdt_sec_tick.sv
// One-second tick generator for the timeout counters
`timescale 1ns/1ps
`default_nettype none
`include "bdt_defines.svh"

module bdt_sec_tick
  import bdt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `BDT_SECOND_CYCLES
) (
  // Clock and reset
  input wire logic  core_clk,
  input wire logic  srst,
  // Tick carrier
  bdt_tick_if.source tickBus
);

  logic [31:0] prescale_reg;
  logic        tick_reg;
  wire  logic  wrapNow;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign wrapNow     = (prescale_reg == SEC_CYCLES - 1);
  assign tickBus.tick = tick_reg;

  // Count cycles, pulse once per full second
  always_ff @(posedge core_clk) begin
    if (srst || tickBus.clear) begin
      prescale_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else begin
      prescale_reg <= wrapNow ? 32'h0 : prescale_reg + 32'h1;
      tick_reg     <= wrapNow;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tick_single: assert property (@(posedge core_clk) disable iff (srst)
    tickBus.tick && !tickBus.clear && SEC_CYCLES > 1 |=> !tickBus.tick)
    else $error("tick lasted more than one cycle");

  a_tick_spacing: assert property (@(posedge core_clk) disable iff (srst)
    $rose(tickBus.tick) |-> $past(prescale_reg) == SEC_CYCLES - 1)
    else $error("tick without a full second");

endmodule : bdt_sec_tick

`default_nettype wire

// file: rtl/bdt_dim_off_timer.sv
// Sink group selection and dim/off timeout sequencing for the backlight group
`timescale 1ns/1ps
`default_nettype none
`include "bdt_defines.svh"

module bdt_dim_off_timer
  import bdt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `BDT_SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Register port from the serial host engine
  input  wire logic       regWrEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // Backlight group and sink control
  input  wire logic       backlightGroupEnable,
  input  wire logic       groupAtMax,
  input  wire logic       userActivity,
  input  wire logic [6:0] ledIndepEnable,
  input  wire logic [3:0] groupFadeOutRate,
  output logic      [6:0] sinkEnable,
  output logic            dimRequest,
  output logic            offRequest,
  output logic      [3:0] fadeOutRateSel,
  output logic            fadeInstant
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bdt_field_t  sinkSelect_reg;
  bdt_field_t  offDelay_reg;
  bdt_field_t  dimDelay_reg;
  bdt_field_t  count_reg;
  bdt_field_t  count_next;
  bdt_state_t  state_reg;
  bdt_state_t  state_next;
  logic        dim_reg;
  logic        dim_next;
  logic        off_reg;
  logic        off_next;
  logic [7:0]  rdData_reg;
  logic [6:0]  sink_reg;
  wire  logic  [6:0] sink_next;
  logic [3:0]  fade_reg;
  logic        instant_reg;
  logic        groupRise_reg;
  wire  logic  dimEnabled;
  wire  logic  offEnabled;
  wire  logic  lastSecond;
  wire  logic  restart;
  wire  logic  [7:0] rdData_next;

  bdt_tick_if tickBus ();

  // Address match, used for writes and reads
  function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] offs);
    return addr == offs;
  endfunction

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  bdt_sec_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_sec_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .tickBus  (tickBus.source)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign rdData_next =
      hitReg(regAddr, `BDT_SINK_SELECT_ADDR) ? {1'b0, sinkSelect_reg} :
      hitReg(regAddr, `BDT_OFF_DELAY_ADDR)   ? {1'b0, offDelay_reg}   :
      hitReg(regAddr, `BDT_DIM_DELAY_ADDR)   ? {1'b0, dimDelay_reg}   : 8'h00;

  // Store writes, bit 7 reserved and reads zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sinkSelect_reg <= `BDT_SINK_SELECT_RESET;
      offDelay_reg   <= `BDT_OFF_DELAY_RESET;
      dimDelay_reg   <= `BDT_DIM_DELAY_RESET;
      rdData_reg     <= 8'h00;
    end else begin
      if (regWrEn && hitReg(regAddr, `BDT_SINK_SELECT_ADDR)) sinkSelect_reg <= regWrData[6:0];
      if (regWrEn && hitReg(regAddr, `BDT_OFF_DELAY_ADDR))   offDelay_reg   <= regWrData[6:0];
      if (regWrEn && hitReg(regAddr, `BDT_DIM_DELAY_ADDR))   dimDelay_reg   <= regWrData[6:0];
      rdData_reg <= rdData_next;
    end
  end

  // ----------------------------------------------------------------
  // Timeout sequencer
  // ----------------------------------------------------------------
  assign dimEnabled = (dimDelay_reg != 7'h00);
  assign offEnabled = (offDelay_reg != 7'h00);
  assign lastSecond = tickBus.tick && (count_reg == 7'h01);
  assign restart    = userActivity || (backlightGroupEnable && !groupRise_reg);

  // Next state, counter and requests
  always_comb begin
    state_next    = state_reg;
    count_next    = count_reg;
    dim_next      = dim_reg;
    off_next      = off_reg;
    tickBus.clear = 1'b0;
    if (!backlightGroupEnable) begin
      state_next = BDT_IDLE;
      dim_next   = 1'b0;
      off_next   = 1'b0;
    end else if (restart) begin
      state_next    = BDT_WAIT_MAX;
      dim_next      = 1'b0;
      off_next      = 1'b0;
      tickBus.clear = 1'b1;
    end else begin
      unique case (state_reg)
        BDT_IDLE: begin
          state_next = BDT_WAIT_MAX;
        end
        BDT_WAIT_MAX: begin
          if (groupAtMax) begin
            tickBus.clear = 1'b1;
            if (dimEnabled) begin
              state_next = BDT_DIM_RUN;
              count_next = dimDelay_reg;
            end else if (offEnabled) begin
              state_next = BDT_OFF_RUN;
              count_next = offDelay_reg;
            end else begin
              state_next = BDT_HOLD;
            end
          end
        end
        BDT_DIM_RUN: begin
          if (lastSecond) begin
            dim_next      = 1'b1;
            tickBus.clear = 1'b1;
            if (offEnabled) begin
              state_next = BDT_OFF_RUN;
              count_next = offDelay_reg;
            end else begin
              state_next = BDT_HOLD;
            end
          end else if (tickBus.tick) begin
            count_next = count_reg - 7'h01;
          end
        end
        BDT_OFF_RUN: begin
          if (lastSecond) begin
            off_next   = 1'b1;
            state_next = BDT_HOLD;
          end else if (tickBus.tick) begin
            count_next = count_reg - 7'h01;
          end
        end
        BDT_HOLD: begin
          state_next = BDT_HOLD;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg     <= BDT_IDLE;
      count_reg     <= 7'h00;
      dim_reg       <= 1'b0;
      off_reg       <= 1'b0;
      groupRise_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      count_reg     <= count_next;
      dim_reg       <= dim_next;
      off_reg       <= off_next;
      groupRise_reg <= backlightGroupEnable;
    end
  end

  // ----------------------------------------------------------------
  // Sink routing
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `BDT_SINK_COUNT; gi++) begin : g_sink
      assign sink_next[gi] = sinkSelect_reg[gi] ? ledIndepEnable[gi]
                                                : (backlightGroupEnable && !off_next);
    end
  endgenerate

  // Output flops for sinks and fade selection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sink_reg    <= 7'h00;
      fade_reg    <= `BDT_FADE_DISABLED;
      instant_reg <= 1'b1;
    end else begin
      sink_reg    <= sink_next;
      fade_reg    <= groupFadeOutRate;
      instant_reg <= (groupFadeOutRate == `BDT_FADE_DISABLED);
    end
  end

  assign regRdData      = rdData_reg;
  assign sinkEnable     = sink_reg;
  assign dimRequest     = dim_reg;
  assign offRequest     = off_reg;
  assign fadeOutRateSel = fade_reg;
  assign fadeInstant    = instant_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_indep_sink: assert property (@(posedge core_clk) disable iff (srst)
    sinkSelect_reg[0] |=> sinkEnable[0] == $past(ledIndepEnable[0]))
    else $error("independent sink did not follow its own enable");

  a_group_sink: assert property (@(posedge core_clk) disable iff (srst)
    !sinkSelect_reg[6] && !backlightGroupEnable |=> !sinkEnable[6])
    else $error("grouped sink stayed on with group disabled");

  a_off_expiry: assert property (@(posedge core_clk) disable iff (srst)
    $rose(offRequest)
      |-> $past(state_reg) == BDT_OFF_RUN && $past(tickBus.tick) && $past(count_reg) == 7'h01)
    else $error("off request without off expiry");

  a_off_after_dim: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == BDT_DIM_RUN && !restart && backlightGroupEnable && !lastSecond
      |=> state_reg == BDT_DIM_RUN)
    else $error("off countdown began before dim finished");

  a_off_disabled: assert property (@(posedge core_clk) disable iff (srst)
    offDelay_reg == 7'h00 && state_reg == BDT_WAIT_MAX |=> state_reg != BDT_OFF_RUN)
    else $error("off countdown ran with zero delay");

  a_dim_expiry: assert property (@(posedge core_clk) disable iff (srst)
    $rose(dimRequest)
      |-> $past(state_reg) == BDT_DIM_RUN && $past(tickBus.tick) && $past(count_reg) == 7'h01)
    else $error("dim request without dim expiry");

  a_dim_waits_max: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == BDT_WAIT_MAX && !groupAtMax |=> state_reg != BDT_DIM_RUN)
    else $error("dim countdown started below maximum current");

  a_dim_load: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == BDT_WAIT_MAX && groupAtMax && dimEnabled && !restart && backlightGroupEnable
      |=> state_reg == BDT_DIM_RUN && count_reg == $past(dimDelay_reg))
    else $error("dim countdown not loaded with delay");

  a_fade_instant: assert property (@(posedge core_clk) disable iff (srst)
    ##1 fadeInstant == ($past(groupFadeOutRate) == `BDT_FADE_DISABLED))
    else $error("instant fade flag wrong");

  a_restart_clears: assert property (@(posedge core_clk) disable iff (srst)
    userActivity && backlightGroupEnable |=> !dimRequest && !offRequest && state_reg == BDT_WAIT_MAX)
    else $error("activity did not restart the timeouts");

endmodule : bdt_dim_off_timer

`default_nettype wire

// file: dv/bdt_host_model.sv
// Host processor model that programs the timer registers byte by byte
`timescale 1ns/1ps
`default_nettype none

module bdt_host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic            regWrEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  // Idle bus at time zero
  initial begin
    regWrEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // One write, strobe held across the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn   <= 1'b0;
    regWrData <= ~d;  // Released data does not keep its value
  endtask

  // Read with one edge of latency
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    @(posedge core_clk);
    #1;
    d = regRdData;
  endtask
endmodule // bdt_host_model

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the sink select and dim/off timer
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int SC = 8;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic       regWrEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic       backlightGroupEnable = 1'b0;
  logic       groupAtMax = 1'b0;
  logic       userActivity = 1'b0;
  logic [6:0] ledIndepEnable = 7'h00;
  logic [3:0] groupFadeOutRate = 4'h0;
  logic [6:0] sinkEnable;
  logic       dimRequest;
  logic       offRequest;
  logic [3:0] fadeOutRateSel;
  logic       fadeInstant;
  int         fail_count = 0;
  int         num_checks = 0;
  logic [7:0] rv;
  int         n;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #5 core_clk = ~core_clk;

  bdt_dim_off_timer #(.SEC_CYCLES(SC)) u_bdt_dim_off_timer (
    .core_clk(core_clk), .srst(srst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .backlightGroupEnable(backlightGroupEnable),
    .groupAtMax(groupAtMax), .userActivity(userActivity), .ledIndepEnable(ledIndepEnable),
    .groupFadeOutRate(groupFadeOutRate), .sinkEnable(sinkEnable), .dimRequest(dimRequest),
    .offRequest(offRequest), .fadeOutRateSel(fadeOutRateSel), .fadeInstant(fadeInstant));

  bdt_host_model u_bdt_host_model (
    .core_clk(core_clk), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  // ----------------------------------------------------------------
  // Compare and wait helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // Cycles until dim (sel 0) or off (sel 1) request is high
  task automatic wait_req(input int sel, output int cyc);
    for (cyc = 1; cyc < 40 * SC; cyc++) begin
      @(posedge core_clk);
      #1;
      if ((sel == 0 ? dimRequest : offRequest) === 1'b1) return;
    end
    fail_count++;
    $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
    tally_and_finish();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 5; a <= 9; a++) begin
      u_bdt_host_model.rd(8'(a), rv);
      chk(rv, 8'h00);
      u_bdt_host_model.wr(8'(a), 8'hff);
      u_bdt_host_model.rd(8'(a), rv);
      chk(rv, (a <= 7) ? 8'h7f : 8'h00);
      u_bdt_host_model.wr(8'(a), 8'h00);
    end
    $display("test regs done");
  endtask

  task automatic t_sink();
    u_bdt_host_model.wr(8'h05, 8'h55);
    @(posedge core_clk);
    backlightGroupEnable <= 1'b1;
    ledIndepEnable       <= 7'h0f;
    cyc(3);
    chk({1'b0, sinkEnable}, 8'h2f);
    @(posedge core_clk);
    ledIndepEnable <= 7'h70;
    cyc(3);
    chk({1'b0, sinkEnable}, 8'h7a);
    u_bdt_host_model.wr(8'h05, 8'h00);
    cyc(3);
    chk({1'b0, sinkEnable}, 8'h7f);
    $display("test sink done");
  endtask

  task automatic t_dim_off();
    @(posedge core_clk);
    backlightGroupEnable <= 1'b0;
    u_bdt_host_model.wr(8'h07, 8'h02);
    u_bdt_host_model.wr(8'h06, 8'h01);
    @(posedge core_clk);
    backlightGroupEnable <= 1'b1;
    cyc(5 * SC);
    chk({7'h00, dimRequest}, 8'h00);
    @(posedge core_clk);
    groupAtMax <= 1'b1;
    wait_req(0, n);
    chk_span(n, 2 * SC - 1, 2 * SC + 3);
    chk({7'h00, offRequest}, 8'h00);
    wait_req(1, n);
    chk_span(n, SC - 1, SC + 3);
    chk({1'b0, sinkEnable}, 8'h00);
    $display("test dim off done");
  endtask

  task automatic t_off_only();
    @(posedge core_clk);
    backlightGroupEnable <= 1'b0;
    u_bdt_host_model.wr(8'h07, 8'h00);
    u_bdt_host_model.wr(8'h06, 8'h02);
    @(posedge core_clk);
    backlightGroupEnable <= 1'b1;
    wait_req(1, n);
    chk_span(n, 2 * SC - 1, 2 * SC + 4);
    chk({7'h00, dimRequest}, 8'h00);
    @(posedge core_clk);
    userActivity <= 1'b1;
    @(posedge core_clk);
    userActivity <= 1'b0;
    cyc(2);
    chk({6'h00, dimRequest, offRequest}, 8'h00);
    chk({1'b0, sinkEnable}, 8'h7f);
    wait_req(1, n);
    chk_span(n, 2 * SC - 3, 2 * SC + 3);
    @(posedge core_clk);
    backlightGroupEnable <= 1'b0;
    cyc(3);
    chk({6'h00, dimRequest, offRequest}, 8'h00);
    chk({1'b0, sinkEnable}, 8'h00);
    $display("test off only done");
  endtask

  task automatic t_fade();
    for (int r = 0; r < 16; r++) begin
      @(posedge core_clk);
      groupFadeOutRate <= 4'(r);
      cyc(3);
      chk({3'h0, fadeInstant, fadeOutRateSel}, {3'h0, r == 0, 4'(r)});
    end
    $display("test fade done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    cyc(1);
    chk({sinkEnable, fadeInstant}, 8'h01);
    chk({6'h00, dimRequest, offRequest}, 8'h00);
    t_regs();
    t_sink();
    t_dim_off();
    t_off_only();
    t_fade();
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
